/* hw/ctx_entry_walk_config_decoder.sv */
// Context entry decoder: walk depth, root pointer, checks and faults
//
// How it works
// - Reserved bits 71, 11:6 checked when present
// - Software free bits 70:67 always ignored
// - Multi-level types use width field 66:64
// - Width codes map to width and levels
// - Root pointer taken from bits 63:12
// - Root bits at/above host width reserved
// - Width and root evaluated only when present
// - Hint set allows prefetch of adjacent mappings
// - Prefetch faults silently dropped, never reported
// - No hint support: hint bit reserved
// - Hint evaluated only when present
// - Not present blocks DMA, else process
// - Pass-through passes untranslated, blocks others
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ctx_entry_walk_config_decoder (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Prefetch probe from walker
    input wire logic i_pf_fault,
    // Decoded walk settings
    output ctx_decode_pkg::walk_cfg_s o_cfg,
    output logic o_prefetch_en,
    // Request verdict
    output logic o_req_done,
    output logic o_req_pass,
    output logic o_req_walk,
    output logic o_req_block,
    output logic [63:0] o_req_addr,
    // Interrupt
    output logic o_irq
);
    import ctx_decode_pkg::*;

    logic [95:0] entry_q; // Lower 96 bits of the entry
    logic [4:0] supp_q; // Supported width set, one bit per code
    logic [6:0] haw_q; // Host address width
    logic hint_sup_q; // Caching hint support
    logic [3:0] status_q; // Sticky events
    logic [3:0] mask_q; // Interrupt mask
    logic [63:0] req_addr_q; // Request address
    logic [1:0] req_kind_q; // Request kind
    logic go_q; // Request pending this cycle
    logic [6:0] lut_width;
    logic [2:0] lut_levels;
    logic lut_defined;
    logic present;
    logic [1:0] ttype;
    logic multi;
    logic rsvd_bad;
    logic root_bad;
    logic width_bad;
    logic prog_fault;
    logic range_bad;
    logic [3:0] ev;

    // Mask of address bits at or above a width
    function automatic logic [63:0] above_mask(input logic [6:0] w);
        logic [63:0] m;
        m = 64'hFFFF_FFFF_FFFF_FFFF;
        if (w >= 7'h40) begin
            m = 64'h0;
        end else begin
            m = m << w[5:0];
        end
        return m;
    endfunction

    walk_width_lut u_lut (
        .i_code(entry_q[WIDTH_LSB+2:WIDTH_LSB]),
        .o_width(lut_width),
        .o_levels(lut_levels),
        .o_defined(lut_defined)
    );

    // Field extraction; bits 70:67 never read
    assign present = entry_q[PRESENT_BIT];
    assign ttype = entry_q[TTYPE_LO+1:TTYPE_LO];
    assign multi = (ttype == TT_MULTI) || (ttype == TT_MULTI_DEV);
    // Hint bit reserved when hints unsupported
    assign rsvd_bad = entry_q[RSVD_HI_BIT]
        | (|entry_q[RSVD_LO_MSB:RSVD_LO_LSB])
        | (~hint_sup_q & entry_q[HINT_BIT]);
    // Pointer bits at or above host width are reserved
    assign root_bad = multi
        && (|(entry_q[ROOT_MSB:0] & above_mask(haw_q)) );
    // Reserved code or code not in the supported set
    assign width_bad = multi && (!lut_defined
        || !supp_q[entry_q[WIDTH_LSB+2:WIDTH_LSB]]);
    // Checks only apply to present entries
    assign prog_fault = present && (rsvd_bad || root_bad || width_bad);
    assign range_bad = |(req_addr_q & above_mask(lut_width));

    // Register writes
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            entry_q <= '0;
            supp_q <= SUPP_RESET;
            haw_q <= HAW_RESET;
            hint_sup_q <= 1'b1;
            mask_q <= 4'h0;
            req_addr_q <= 64'h0;
            req_kind_q <= 2'h0;
        end else if (i_wr) begin
            case (i_addr)
                OFF_ENTRY0: entry_q[31:0] <= i_wdata;
                OFF_ENTRY1: entry_q[63:32] <= i_wdata;
                OFF_ENTRY2: entry_q[95:64] <= i_wdata;
                OFF_CFG: begin
                    supp_q <= i_wdata[4:0];
                    haw_q <= i_wdata[14:8];
                    hint_sup_q <= i_wdata[16];
                end
                OFF_MASK: mask_q <= i_wdata[3:0];
                OFF_REQ_LO: req_addr_q[31:0] <= i_wdata;
                OFF_REQ_HI: req_addr_q[63:32] <= i_wdata;
                OFF_REQ_GO: req_kind_q <= i_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // Request trigger: one cycle after a go write
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            go_q <= 1'b0;
        end else begin
            go_q <= i_wr && (i_addr == OFF_REQ_GO);
        end
    end

    // Request verdict; one-cycle pulses
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_req_done <= 1'b0;
            o_req_pass <= 1'b0;
            o_req_walk <= 1'b0;
            o_req_block <= 1'b0;
            o_req_addr <= 64'h0;
        end else begin
            o_req_done <= go_q;
            o_req_pass <= 1'b0;
            o_req_walk <= 1'b0;
            o_req_block <= 1'b0;
            if (go_q) begin
                o_req_addr <= req_addr_q;
                if (!present || prog_fault) begin
                    o_req_block <= 1'b1;
                end else if (ttype == TT_PASS) begin
                    // Untranslated passes as is; others blocked
                    if (req_kind_q == REQ_UNTRANS) begin
                        o_req_pass <= 1'b1;
                    end else begin
                        o_req_block <= 1'b1;
                    end
                end else if (!multi) begin
                    o_req_block <= 1'b1;
                end else if (range_bad) begin
                    o_req_block <= 1'b1;
                end else if (ttype == TT_MULTI
                    && req_kind_q != REQ_UNTRANS) begin
                    o_req_block <= 1'b1;
                end else begin
                    o_req_walk <= 1'b1;
                end
            end
        end
    end

    // Decoded walk settings, held only while present
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cfg <= '0;
            o_prefetch_en <= 1'b0;
        end else begin
            o_cfg.valid <= present && multi && !prog_fault;
            o_cfg.levels <= (present && multi) ? lut_levels : 3'h0;
            o_cfg.width <= (present && multi) ? lut_width : 7'h00;
            // Root ignored for pass-through
            o_cfg.root <= (present && multi)
                ? entry_q[ROOT_MSB:ROOT_LSB] : 52'h0;
            o_cfg.hint <= present && hint_sup_q
                && entry_q[HINT_BIT];
            o_cfg.prog_fault <= prog_fault;
            // Prefetch allowed only on a clean multi-level entry
            o_prefetch_en <= present && hint_sup_q && entry_q[HINT_BIT]
                && multi && !prog_fault;
        end
    end

    // Events; prefetch faults never enter here
    assign ev[ST_PROG] = prog_fault && !o_cfg.prog_fault;
    assign ev[ST_RANGE] = go_q && present && multi && !prog_fault
        && range_bad;
    assign ev[ST_BLOCK] = go_q && (!present || prog_fault);
    assign ev[ST_PASS] = go_q && present && !prog_fault
        && ttype == TT_PASS && req_kind_q != REQ_UNTRANS;

    // Sticky status; read clears, new event wins
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            status_q <= 4'h0;
        end else begin
            if (i_rd && i_addr == OFF_STATUS) begin
                status_q <= ev;
            end else begin
                status_q <= status_q | ev;
            end
        end
    end

    // Interrupt level
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((status_q | ev) & mask_q);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            case (i_addr)
                OFF_ENTRY0: o_rdata <= entry_q[31:0];
                OFF_ENTRY1: o_rdata <= entry_q[63:32];
                OFF_ENTRY2: o_rdata <= entry_q[95:64];
                OFF_CFG: o_rdata <= {15'h0, hint_sup_q, 1'b0, haw_q,
                    3'h0, supp_q};
                OFF_STATUS: o_rdata <= {28'h0, status_q};
                OFF_MASK: o_rdata <= {28'h0, mask_q};
                OFF_DECODE: o_rdata <= {19'h0, prog_fault, present, 1'b0,
                    lut_levels, lut_width};
                OFF_REQ_LO: o_rdata <= req_addr_q[31:0];
                OFF_REQ_HI: o_rdata <= req_addr_q[63:32];
                OFF_REQ_GO: o_rdata <= {30'h0, req_kind_q};
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // Guards
    property p_block_absent;
        @(posedge i_core_clk) disable iff (!i_rstn)
        go_q && !present |=> o_req_block && !o_req_walk && !o_req_pass;
    endproperty
    a_block_absent: assert property (p_block_absent)
        else $error("absent entry not blocked");

    property p_pass_untrans;
        @(posedge i_core_clk) disable iff (!i_rstn)
        go_q && present && !prog_fault && ttype == TT_PASS
            && req_kind_q == REQ_UNTRANS |=> o_req_pass;
    endproperty
    a_pass_untrans: assert property (p_pass_untrans)
        else $error("pass-through request not passed");

    property p_range;
        @(posedge i_core_clk) disable iff (!i_rstn)
        go_q && present && multi && !prog_fault && range_bad
            |=> o_req_block ##1 status_q[ST_RANGE];
    endproperty
    a_range: assert property (p_range)
        else $error("out of range request not faulted");

    property p_levels;
        @(posedge i_core_clk) disable iff (!i_rstn)
        present && multi && entry_q[WIDTH_LSB+2:WIDTH_LSB] == 3'h2
            |=> o_cfg.levels == 3'h4 && o_cfg.width == 7'h30;
    endproperty
    a_levels: assert property (p_levels)
        else $error("width code 2 decoded wrong");

    property p_reserved_code;
        @(posedge i_core_clk) disable iff (!i_rstn)
        present && multi && entry_q[WIDTH_LSB+2:WIDTH_LSB] > WIDTH_CODE_MAX
            |=> o_cfg.prog_fault && !o_cfg.valid;
    endproperty
    a_reserved_code: assert property (p_reserved_code)
        else $error("reserved width code accepted");

    property p_absent_quiet;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !present |=> !o_cfg.prog_fault && !o_cfg.hint && o_cfg.root == 52'h0;
    endproperty
    a_absent_quiet: assert property (p_absent_quiet)
        else $error("absent entry evaluated");

    property p_rsvd;
        @(posedge i_core_clk) disable iff (!i_rstn)
        present && entry_q[RSVD_HI_BIT] |=> o_cfg.prog_fault;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit 71 missed");

    property p_pf_silent;
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_pf_fault && !go_q && $stable(entry_q) && !o_irq
            && (status_q & mask_q) == 4'h0 |=> !o_irq;
    endproperty
    a_pf_silent: assert property (p_pf_silent)
        else $error("prefetch fault reported");

    property p_root;
        @(posedge i_core_clk) disable iff (!i_rstn)
        present && multi |=> o_cfg.root == $past(entry_q[ROOT_MSB:ROOT_LSB]);
    endproperty
    a_root: assert property (p_root)
        else $error("root pointer wrong");
endmodule
`default_nettype wire

/* hw/ctx_decode_pkg.sv */
// Shared constants and carriers for the context entry walk decoder
package ctx_decode_pkg;

    // Entry field positions
    localparam int PRESENT_BIT = 0;
    localparam int FAULT_OFF_BIT = 1;
    localparam int TTYPE_LO = 2;
    localparam int HINT_BIT = 5;
    localparam int RSVD_LO_LSB = 6;
    localparam int RSVD_LO_MSB = 11;
    localparam int ROOT_LSB = 12;
    localparam int ROOT_MSB = 63;
    localparam int WIDTH_LSB = 64;
    localparam int FREE_LSB = 67;
    localparam int FREE_MSB = 70;
    localparam int RSVD_HI_BIT = 71;

    // Translation type encodings
    localparam logic [1:0] TT_MULTI = 2'h0;
    localparam logic [1:0] TT_MULTI_DEV = 2'h1;
    localparam logic [1:0] TT_PASS = 2'h2;

    // Highest defined width code
    localparam logic [2:0] WIDTH_CODE_MAX = 3'h4;
    localparam logic [4:0] SUPP_RESET = 5'h04;
    localparam logic [6:0] HAW_RESET = 7'h30;

    // Register offsets
    localparam logic [3:0] OFF_ENTRY0 = 4'h0;
    localparam logic [3:0] OFF_ENTRY1 = 4'h1;
    localparam logic [3:0] OFF_ENTRY2 = 4'h2;
    localparam logic [3:0] OFF_CFG = 4'h3;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK = 4'h5;
    localparam logic [3:0] OFF_DECODE = 4'h6;
    localparam logic [3:0] OFF_REQ_LO = 4'h7;
    localparam logic [3:0] OFF_REQ_HI = 4'h8;
    localparam logic [3:0] OFF_REQ_GO = 4'h9;

    // Status bit positions
    localparam int ST_PROG = 0;
    localparam int ST_RANGE = 1;
    localparam int ST_BLOCK = 2;
    localparam int ST_PASS = 3;

    // Request kinds
    typedef enum logic [1:0] {
        REQ_UNTRANS = 2'b00,
        REQ_TRANSLATED = 2'b01,
        REQ_XLATE = 2'b10
    } req_kind_e;

    // Decoded walk settings
    typedef struct packed {
        logic valid;
        logic [2:0] levels;
        logic [6:0] width;
        logic [51:0] root;
        logic hint;
        logic prog_fault;
    } walk_cfg_s;

endpackage

/* hw/walk_width_lut.sv */
// Width code to walk width and level count lookup
`timescale 1ns/1ps
`default_nettype none
module walk_width_lut (
    // Code in
    input wire logic [2:0] i_code,
    // Decoded out
    output logic [6:0] o_width,
    output logic [2:0] o_levels,
    output logic o_defined
);
    import ctx_decode_pkg::*;

    // Fixed decode; codes above the max are reserved
    always_comb begin
        o_defined = 1'b1;
        case (i_code)
            3'h0: begin o_width = 7'h1E; o_levels = 3'h2; end
            3'h1: begin o_width = 7'h27; o_levels = 3'h3; end
            3'h2: begin o_width = 7'h30; o_levels = 3'h4; end
            3'h3: begin o_width = 7'h39; o_levels = 3'h5; end
            3'h4: begin o_width = 7'h40; o_levels = 3'h6; end
            default: begin
                o_width = 7'h00;
                o_levels = 3'h0;
                o_defined = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* tb/walk_partner.sv */
// Page walker model that reports faults on prefetched mappings
`timescale 1ns/1ps
`default_nettype none
module walk_partner (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Prefetch permission from the decoder
    input wire logic i_prefetch_en,
    // Fault found on a prefetched mapping
    output logic o_pf_fault
);
    logic [7:0] lfsr_q; // Fault pattern source

    // Faults only while prefetch is allowed, irregular so edges vary
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lfsr_q <= 8'hA5;
            o_pf_fault <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]};
            o_pf_fault <= i_prefetch_en & lfsr_q[0];
        end
    end
endmodule
`default_nettype wire

/* tb/ctx_entry_walk_config_decoder_tb.sv */
// Self-checking bench for the context entry decoder
`timescale 1ns/1ps
`default_nettype none
module ctx_entry_walk_config_decoder_tb;
    import ctx_decode_pkg::*;
    logic i_core_clk, i_rstn, i_wr, i_rd, pf_fault, rd_d;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, em, ee;
    walk_cfg_s o_cfg;
    logic o_prefetch_en, o_req_done, o_req_pass, o_req_walk;
    logic o_req_block, o_irq;
    logic [63:0] o_req_addr, a;
    logic [95:0] e;
    logic [31:0] rd_q[$], msk_q[$]; // Expected read data and masks
    logic [66:0] vd_q[$]; // Expected verdict and address
    logic [6:0] wt [0:4] = '{7'h1E, 7'h27, 7'h30, 7'h39, 7'h40};
    int n_fail, cmp_count;
    integer seed = 32'h2537;
    // Base entry: present, multi-level, code 2, root page 1
    localparam logic [95:0] B = {32'h2, 32'h0, 32'h1001};
    localparam logic [31:0] C1 = 32'h0001_301F; // All widths, hints

    ctx_entry_walk_config_decoder dut (.i_core_clk(i_core_clk),
        .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_pf_fault(pf_fault),
        .o_cfg(o_cfg), .o_prefetch_en(o_prefetch_en),
        .o_req_done(o_req_done), .o_req_pass(o_req_pass),
        .o_req_walk(o_req_walk), .o_req_block(o_req_block),
        .o_req_addr(o_req_addr), .o_irq(o_irq));
    walk_partner walker (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_prefetch_en(o_prefetch_en), .o_pf_fault(pf_fault));

    // Clock at 50 MHz
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    task automatic chk(string nm, logic [66:0] x, logic [66:0] g);
        cmp_count++;
        if (g !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Each bus task sets both strobes once, so calls chain with no gap
    task automatic wr(logic [3:0] ad, logic [31:0] d);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic rd(logic [3:0] ad, logic [31:0] x, logic [31:0] m);
        rd_q.push_back(x);
        msk_q.push_back(m);
        i_addr <= ad;
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
    endtask
    task automatic idle(int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic ent(logic [95:0] v);
        wr(OFF_ENTRY0, v[31:0]);
        wr(OFF_ENTRY1, v[63:32]);
        wr(OFF_ENTRY2, v[95:64]);
    endtask
    // Program config and entry, then read the decode view
    task automatic fcase(logic [95:0] v, logic [31:0] c, logic [31:0] x);
        wr(OFF_CFG, c);
        ent(v);
        idle(2);
        rd(OFF_DECODE, x, 32'h1800);
    endtask
    task automatic go(logic [1:0] k, logic [63:0] ad, logic [2:0] x);
        wr(OFF_REQ_LO, ad[31:0]);
        wr(OFF_REQ_HI, ad[63:32]);
        vd_q.push_back({x, ad});
        wr(OFF_REQ_GO, {30'h0, k});
    endtask
    task automatic wrap_up();
        if (rd_q.size() != 0 || vd_q.size() != 0) n_fail++;
        $display("Checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watcher: read data in the cycle after a read, verdict pulses
    always @(posedge i_core_clk) begin
        if (rd_d && rd_q.size() > 0) begin
            ee = rd_q.pop_front();
            em = msk_q.pop_front();
            chk("rdata", ee & em, o_rdata & em);
        end
        if (o_req_done === 1'b1 && vd_q.size() > 0) begin
            chk("verdict", vd_q.pop_front(),
                {o_req_pass, o_req_walk, o_req_block, o_req_addr});
        end
        rd_d <= i_rd;
    end

    // Watchdog
    initial begin
        #200us;
        n_fail++;
        wrap_up();
    end

    initial begin
        {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
        repeat (2) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        rd(OFF_CFG, 32'h0001_3004, 32'hFFFF_FFFF);
        rd(OFF_STATUS, 32'h0, 32'hFFFF_FFFF);
        rd(4'hA, 32'h0, 32'hFFFF_FFFF);
        wr(OFF_CFG, C1);
        // Every width code, free bits and root random
        for (int c = 0; c < 8; c++) begin
            e = B;
            e[66:64] = c[2:0];
            e[70:67] = 4'($random(seed));
            e[47:12] = 36'({$random(seed), $random(seed)});
            ent(e);
            idle(2);
            if (c < 5) begin
                rd(OFF_DECODE, {20'h0, 2'b10, 3'(c + 2), wt[c]},
                    32'hFFFF_FFFF);
                chk("root", e[63:12], o_cfg.root);
                chk("cfg", {1'b1, 3'(c + 2), wt[c], e[63:12], 2'b00},
                    o_cfg);
            end else begin
                rd(OFF_DECODE, 32'h1800, 32'h1800);
                chk("cfg", {11'h0, e[63:12], 2'b01}, o_cfg);
            end
        end
        fcase(B | (96'h1 << 71), C1, 32'h1800);
        fcase(B | 96'h100, C1, 32'h1800);
        fcase((B | (96'h1 << 71)) & ~96'h1, C1, 32'h0);
        fcase(B | (96'h1 << 48), C1, 32'h1800);
        fcase(B ^ (96'h3 << 64), 32'h0001_3004, 32'h1800);
        fcase(B | 96'h20, 32'h0000_3004, 32'h1800);
        fcase((B | 96'h20) & ~96'h1, 32'h0000_3004, 32'h0);
        fcase(B | 96'h20, 32'h0001_3004, 32'h0800);
        chk("prefetch", 1'b1, o_prefetch_en);
        rd(OFF_STATUS, 32'h1, 32'hFFFF_FFFF);
        wr(OFF_MASK, 32'hF);
        idle(6);
        chk("irq quiet", 1'b0, o_irq);
        go(REQ_UNTRANS, 64'h0000_FFFF_FFFF_F000, 3'b010);
        go(REQ_UNTRANS, 64'h0001_0000_0000_0000, 3'b001);
        idle(3);
        chk("irq", 1'b1, o_irq);
        rd(OFF_STATUS, 32'h2, 32'hFFFF_FFFF);
        idle(3);
        chk("irq clear", 1'b0, o_irq);
        ent(B | 96'h8);
        a = {$random(seed), $random(seed)};
        go(REQ_UNTRANS, a, 3'b100);
        go(REQ_TRANSLATED, a, 3'b001);
        go(REQ_XLATE, a, 3'b001);
        idle(3);
        rd(OFF_STATUS, 32'h8, 32'hFFFF_FFFF);
        ent(B & ~96'h1);
        go(REQ_UNTRANS, 64'h1000, 3'b001);
        idle(3);
        rd(OFF_STATUS, 32'h4, 32'hFFFF_FFFF);
        wr(OFF_MASK, 32'h0);
        go(REQ_UNTRANS, 64'h2000, 3'b001);
        idle(4);
        chk("irq masked", 1'b0, o_irq);
        idle(4);
        wrap_up();
    end
endmodule
`default_nettype wire
